//--- src/isd_pkg.sv
// Constants, types and register map of the slave data and time-out block
package isd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices on the plain register port
   localparam logic [2:0] ADDR_BYTE_BUFFER = 3'h0;
   localparam logic [2:0] ADDR_OWN_ADDRESS = 3'h1;
   localparam logic [2:0] ADDR_PRIMARY_CTRL = 3'h2;
   localparam logic [2:0] ADDR_SLAVE_CTRL = 3'h3;
   localparam logic [2:0] ADDR_TIMEOUT_CTRL = 3'h4;
   localparam logic [2:0] ADDR_IRQ_STATUS = 3'h5;
   localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int PRIM_ENABLE_BIT = 0;
   localparam int SCS_BUSY_BIT = 7;
   localparam int SCS_MATCH_BIT = 6;
   localparam int SCS_TXMODE_BIT = 4;
   localparam int SCS_ACKSEND_BIT = 3;
   localparam int SCS_READREQ_BIT = 2;
   localparam int SCS_ACKRX_BIT = 0;
   localparam int TOC_ENABLE_BIT = 7;
   localparam int TOC_FLAG_BIT = 6;
   localparam int IRQ_MATCH_BIT = 0;
   localparam int IRQ_BYTE_BIT = 1;
   localparam int IRQ_TOUT_BIT = 2;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [5:0] RST_TOUT_SEL = 6'h00;
   localparam logic [2:0] RST_IRQ = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // Timing: 20 MHz system clock, sub clock derived by an enable divider
   localparam int CLOCK_HZ = 20_000_000;
   localparam int SUB_CLOCK_HZ = 32_768;
   localparam int SUB_DIV_CYCLES = CLOCK_HZ / SUB_CLOCK_HZ;
   localparam logic [9:0] SUB_DIV_LAST = 10'(SUB_DIV_CYCLES - 1);
   localparam logic [4:0] TOUT_PRESCALE_LAST = 5'h1F;   // divide by 32
   localparam logic [2:0] BIT_LAST = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // Byte engine states
   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_ADDR      = 4'b0001,
      ST_ADDR_ACK  = 4'b0010,
      ST_ACK_HOLD  = 4'b0011,
      ST_STRETCH   = 4'b0100,
      ST_RX        = 4'b0101,
      ST_RX_ACK    = 4'b0110,
      ST_RX_ACKD   = 4'b0111,
      ST_TX        = 4'b1000,
      ST_TX_ACK    = 4'b1001,
      ST_TX_ACKD   = 4'b1010,
      ST_WAIT_STOP = 4'b1011
   } isd_state_e_t;

   // Register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } isd_reg_req_t;

   // Bus pin inputs
   typedef struct packed {
      logic scl_i;
      logic sda_i;
   } isd_pin_in_t;

   // Bus pin outputs, enables low while driving
   typedef struct packed {
      logic scl_o;
      logic scl_oe_n;
      logic sda_o;
      logic sda_oe_n;
   } isd_pin_out_t;

endpackage : isd_pkg

//--- src/isd_slave_timeout.sv
// Slave data phase, clock stretching and bus time-out engine
//
// Overview of operation
// - Bytes are eight bits, MSB first, only after address acknowledge.
// - Receiver drives acknowledge low after every eight data bits while ack_to_send is zero.
// - Transmitter releases data line when master does not acknowledge.
// - Received bytes go to data buffer; transmit bytes come from it.
// - As receiver, software acknowledge value is driven on ninth clock.
// - Transmitter records ninth-clock acknowledge, continues only on acknowledge.
// - After address match, clock held low until buffer write or read.
// - Time-out count starts on START plus match, cleared per clock fall.
// - Time-out when counted time passes selected period before clock fall.
// - Time-out counting stops when STOP is seen.
// - On overflow counter halts, enable clears, flag sets.
// - Time-out raises the shared slave interrupt.
// - Time-out resets engine and slave control/status; other registers kept.
// - Time-out flag set by hardware only, cleared by writing zero.
// - Period is (select plus one) times 32 sub clock periods.
// - Time-out control: bit7 enable, bit6 flag, bits5-0 period, reset zero.
// - Matching address sets flag, stores read bit, acknowledges, interrupts.
`timescale 1ns/100ps
module isd_slave_timeout (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register port
   input wire isd_pkg::isd_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // Bus pins
   input wire isd_pkg::isd_pin_in_t pin_in,
   output isd_pkg::isd_pin_out_t pin_out,
   // Interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // Whole module state
   typedef struct packed {
      logic scl_s1, scl_s2, scl_s3;
      logic sda_s1, sda_s2, sda_s3;
      isd_pkg::isd_state_e_t state;
      logic [7:0] shift;
      logic [2:0] bit_cnt;
      logic [7:0] byte_buffer_reg;
      logic [7:0] own_address_reg;
      logic [7:0] serial_primary_ctrl_reg;
      logic bus_busy;
      logic address_match_flag;
      logic transmit_mode;
      logic ack_to_send;
      logic master_read_request;
      logic ack_received_flag;
      logic stretch;
      logic serviced;
      logic timeout_enable;
      logic timeout_flag;
      logic [5:0] timeout_period_select;
      logic tout_run;
      logic [9:0] sub_div;
      logic [4:0] prescale;
      logic [5:0] units;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic [7:0] rdata;
      isd_pkg::isd_pin_out_t pins;
      logic irq;
   } isd_regs_t;

   isd_regs_t s_q;
   isd_regs_t s_d;

   // Bus condition decode from synchronised pins
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sub_tick;
   logic [7:0] rx_byte;

   assign scl_rise = s_q.scl_s2 & ~s_q.scl_s3;
   assign scl_fall = ~s_q.scl_s2 & s_q.scl_s3;
   assign start_det = s_q.scl_s2 & s_q.scl_s3 & ~s_q.sda_s2 & s_q.sda_s3;
   assign stop_det = s_q.scl_s2 & s_q.scl_s3 & s_q.sda_s2 & ~s_q.sda_s3;
   assign sub_tick = (s_q.sub_div == isd_pkg::SUB_DIV_LAST);
   assign rx_byte = {s_q.shift[6:0], s_q.sda_s2};

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.rdata = isd_pkg::RST_BYTE;
      s_d.pins.scl_o = 1'b0;
      s_d.pins.sda_o = 1'b0;
      // Two flop synchronisers plus edge history
      s_d.scl_s1 = pin_in.scl_i;
      s_d.scl_s2 = s_q.scl_s1;
      s_d.scl_s3 = s_q.scl_s2;
      s_d.sda_s1 = pin_in.sda_i;
      s_d.sda_s2 = s_q.sda_s1;
      s_d.sda_s3 = s_q.sda_s2;

      // Register writes
      if (reg_req.wr) begin
         case (reg_req.addr)
            isd_pkg::ADDR_BYTE_BUFFER: begin
               s_d.byte_buffer_reg = reg_req.wdata;
               if (s_q.stretch && s_q.transmit_mode &&
                  s_q.state != isd_pkg::ST_STRETCH) begin
                  // Early service in the acknowledge clock: no stretch
                  s_d.serviced = 1'b1;
               end else if (s_q.stretch && s_q.transmit_mode) begin
                  s_d.shift = reg_req.wdata;
                  s_d.pins.sda_oe_n = reg_req.wdata[7];
                  s_d.bit_cnt = 3'h0;
                  s_d.stretch = 1'b0;
                  s_d.pins.scl_oe_n = 1'b1;
                  s_d.state = isd_pkg::ST_TX;
               end
            end
            isd_pkg::ADDR_OWN_ADDRESS: begin
               s_d.own_address_reg = reg_req.wdata;
            end
            isd_pkg::ADDR_PRIMARY_CTRL: begin
               s_d.serial_primary_ctrl_reg = reg_req.wdata;
            end
            isd_pkg::ADDR_SLAVE_CTRL: begin
               s_d.transmit_mode = reg_req.wdata[isd_pkg::SCS_TXMODE_BIT];
               s_d.ack_to_send = reg_req.wdata[isd_pkg::SCS_ACKSEND_BIT];
            end
            isd_pkg::ADDR_TIMEOUT_CTRL: begin
               s_d.timeout_enable = reg_req.wdata[isd_pkg::TOC_ENABLE_BIT];
               s_d.timeout_period_select = reg_req.wdata[5:0];
               if (!reg_req.wdata[isd_pkg::TOC_FLAG_BIT]) begin
                  s_d.timeout_flag = 1'b0;
               end
            end
            isd_pkg::ADDR_IRQ_MASK: begin
               s_d.irq_mask = reg_req.wdata[2:0];
            end
            default: begin
            end
         endcase
      end

      // Register reads and their side effects
      if (reg_req.rd) begin
         case (reg_req.addr)
            isd_pkg::ADDR_BYTE_BUFFER: begin
               s_d.rdata = s_q.byte_buffer_reg;
               if (s_q.stretch && !s_q.transmit_mode &&
                  s_q.state != isd_pkg::ST_STRETCH) begin
                  // Dummy read before the stretch began
                  s_d.serviced = 1'b1;
               end else if (s_q.stretch && !s_q.transmit_mode) begin
                  s_d.stretch = 1'b0;
                  s_d.pins.scl_oe_n = 1'b1;
                  s_d.bit_cnt = 3'h0;
                  s_d.state = isd_pkg::ST_RX;
               end
            end
            isd_pkg::ADDR_OWN_ADDRESS: s_d.rdata = s_q.own_address_reg;
            isd_pkg::ADDR_PRIMARY_CTRL: begin
               s_d.rdata = s_q.serial_primary_ctrl_reg;
            end
            isd_pkg::ADDR_SLAVE_CTRL: begin
               s_d.rdata = {s_q.bus_busy, s_q.address_match_flag, 1'b0,
                  s_q.transmit_mode, s_q.ack_to_send,
                  s_q.master_read_request, 1'b0, s_q.ack_received_flag};
            end
            isd_pkg::ADDR_TIMEOUT_CTRL: begin
               s_d.rdata = {s_q.timeout_enable, s_q.timeout_flag,
                  s_q.timeout_period_select};
            end
            isd_pkg::ADDR_IRQ_STATUS: begin
               s_d.rdata = {5'h00, s_q.irq_status};
               s_d.irq_status = isd_pkg::RST_IRQ;
            end
            isd_pkg::ADDR_IRQ_MASK: s_d.rdata = {5'h00, s_q.irq_mask};
            default: s_d.rdata = isd_pkg::RST_BYTE;
         endcase
      end

      // Bus engine; bus events come after clears so a set wins
      if (!s_q.serial_primary_ctrl_reg[isd_pkg::PRIM_ENABLE_BIT]) begin
         s_d.state = isd_pkg::ST_IDLE;
         s_d.pins.scl_oe_n = 1'b1;
         s_d.pins.sda_oe_n = 1'b1;
         s_d.stretch = 1'b0;
         s_d.bus_busy = 1'b0;
         s_d.tout_run = 1'b0;
      end else if (start_det) begin
         s_d.state = isd_pkg::ST_ADDR;
         s_d.bit_cnt = 3'h0;
         s_d.bus_busy = 1'b1;
         s_d.serviced = 1'b0;
         s_d.address_match_flag = 1'b0;
         s_d.pins.sda_oe_n = 1'b1;
      end else if (stop_det) begin
         s_d.state = isd_pkg::ST_IDLE;
         s_d.bus_busy = 1'b0;
         s_d.stretch = 1'b0;
         s_d.tout_run = 1'b0;
         s_d.pins.scl_oe_n = 1'b1;
         s_d.pins.sda_oe_n = 1'b1;
      end else begin
         case (s_q.state)
            isd_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  s_d.shift = rx_byte;
                  s_d.bit_cnt = s_q.bit_cnt + 3'h1;
                  if (s_q.bit_cnt == isd_pkg::BIT_LAST) begin
                     if (rx_byte[7:1] == s_q.own_address_reg[7:1]) begin
                        s_d.address_match_flag = 1'b1;
                        s_d.master_read_request = rx_byte[0];
                        s_d.irq_status[isd_pkg::IRQ_MATCH_BIT] = 1'b1;
                        s_d.stretch = 1'b1;
                        s_d.tout_run = s_q.timeout_enable;
                        s_d.state = isd_pkg::ST_ADDR_ACK;
                     end else begin
                        s_d.state = isd_pkg::ST_IDLE;
                     end
                  end
               end
            end
            isd_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  s_d.pins.sda_oe_n = 1'b0;
                  s_d.state = isd_pkg::ST_ACK_HOLD;
               end
            end
            isd_pkg::ST_ACK_HOLD: begin
               if (scl_fall) begin
                  s_d.pins.sda_oe_n = 1'b1;
                  s_d.pins.scl_oe_n = 1'b0;
                  s_d.state = isd_pkg::ST_STRETCH;
                  if (s_d.serviced) begin
                     // Already serviced: no stretch, go straight on
                     s_d.serviced = 1'b0;
                     s_d.stretch = 1'b0;
                     s_d.pins.scl_oe_n = 1'b1;
                     s_d.bit_cnt = 3'h0;
                     s_d.state = isd_pkg::ST_RX;
                     if (s_q.transmit_mode) begin
                        s_d.shift = s_d.byte_buffer_reg;
                        s_d.pins.sda_oe_n = s_d.byte_buffer_reg[7];
                        s_d.state = isd_pkg::ST_TX;
                     end
                  end
               end
            end
            isd_pkg::ST_RX: begin
               if (scl_rise) begin
                  s_d.shift = rx_byte;
                  s_d.bit_cnt = s_q.bit_cnt + 3'h1;
                  if (s_q.bit_cnt == isd_pkg::BIT_LAST) begin
                     s_d.byte_buffer_reg = rx_byte;
                     s_d.irq_status[isd_pkg::IRQ_BYTE_BIT] = 1'b1;
                     s_d.state = isd_pkg::ST_RX_ACK;
                  end
               end
            end
            isd_pkg::ST_RX_ACK: begin
               if (scl_fall) begin
                  s_d.pins.sda_oe_n = s_q.ack_to_send;
                  s_d.state = isd_pkg::ST_RX_ACKD;
               end
            end
            isd_pkg::ST_RX_ACKD: begin
               if (scl_fall) begin
                  s_d.pins.sda_oe_n = 1'b1;
                  s_d.bit_cnt = 3'h0;
                  s_d.state = isd_pkg::ST_RX;
               end
            end
            isd_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (s_q.bit_cnt == isd_pkg::BIT_LAST) begin
                     s_d.pins.sda_oe_n = 1'b1;
                     s_d.state = isd_pkg::ST_TX_ACK;
                  end else begin
                     s_d.pins.sda_oe_n = s_q.shift[6];
                     s_d.shift = {s_q.shift[6:0], 1'b0};
                     s_d.bit_cnt = s_q.bit_cnt + 3'h1;
                  end
               end
            end
            isd_pkg::ST_TX_ACK: begin
               if (scl_rise) begin
                  s_d.ack_received_flag = s_q.sda_s2;
                  s_d.irq_status[isd_pkg::IRQ_BYTE_BIT] = 1'b1;
                  s_d.state = isd_pkg::ST_TX_ACKD;
               end
            end
            isd_pkg::ST_TX_ACKD: begin
               if (scl_fall) begin
                  if (!s_q.ack_received_flag) begin
                     s_d.shift = s_q.byte_buffer_reg;
                     s_d.pins.sda_oe_n = s_q.byte_buffer_reg[7];
                     s_d.bit_cnt = 3'h0;
                     s_d.state = isd_pkg::ST_TX;
                  end else begin
                     s_d.pins.sda_oe_n = 1'b1;
                     s_d.state = isd_pkg::ST_WAIT_STOP;
                  end
               end
            end
            isd_pkg::ST_IDLE, isd_pkg::ST_STRETCH,
            isd_pkg::ST_WAIT_STOP: begin
            end
            default: s_d.state = isd_pkg::ST_IDLE;
         endcase
      end

      // Time-out counter: sub clock enable, divide by 32, period units
      if (!s_d.timeout_enable || !s_d.tout_run) begin
         s_d.sub_div = 10'h000;
         s_d.prescale = 5'h00;
         s_d.units = 6'h00;
      end else if (scl_fall) begin
         s_d.sub_div = 10'h000;
         s_d.prescale = 5'h00;
         s_d.units = 6'h00;
      end else begin
         s_d.sub_div = sub_tick ? 10'h000 : s_q.sub_div + 10'h001;
         if (sub_tick) begin
            s_d.prescale = s_q.prescale + 5'h01;
            if (s_q.prescale == isd_pkg::TOUT_PRESCALE_LAST) begin
               if (s_q.units == s_q.timeout_period_select) begin
                  s_d.timeout_enable = 1'b0;
                  s_d.timeout_flag = 1'b1;
                  s_d.tout_run = 1'b0;
                  s_d.sub_div = 10'h000;
                  s_d.prescale = 5'h00;
                  s_d.units = 6'h00;
                  s_d.irq_status[isd_pkg::IRQ_TOUT_BIT] = 1'b1;
                  s_d.state = isd_pkg::ST_IDLE;
                  s_d.pins.scl_oe_n = 1'b1;
                  s_d.pins.sda_oe_n = 1'b1;
                  s_d.stretch = 1'b0;
                  s_d.bus_busy = 1'b0;
                  s_d.address_match_flag = 1'b0;
                  s_d.transmit_mode = 1'b0;
                  s_d.ack_to_send = 1'b0;
                  s_d.master_read_request = 1'b0;
                  s_d.ack_received_flag = 1'b0;
               end else begin
                  s_d.units = s_q.units + 6'h01;
               end
            end
         end
      end

      // Level interrupt from unmasked sticky events
      s_d.irq = |(s_d.irq_status & s_d.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.scl_s1 <= 1'b1;
         s_q.scl_s2 <= 1'b1;
         s_q.scl_s3 <= 1'b1;
         s_q.sda_s1 <= 1'b1;
         s_q.sda_s2 <= 1'b1;
         s_q.sda_s3 <= 1'b1;
         s_q.state <= isd_pkg::ST_IDLE;
         s_q.timeout_period_select <= isd_pkg::RST_TOUT_SEL;
         s_q.pins.scl_oe_n <= 1'b1;
         s_q.pins.sda_oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata = s_q.rdata;
   assign pin_out = s_q.pins;
   assign irq = s_q.irq;

endmodule : isd_slave_timeout

//--- test/isd_master.sv
// Bus master model driving the serial clock and data lines
`timescale 1ns/100ps
module isd_master (
   // Clock
   input wire logic clock,
   // Wire levels
   input wire logic scl_w,
   input wire logic sda_w,
   // Open-drain drives, 1 lets the pull-up win
   output logic scl_m,
   output logic sda_m
);
   // Idle bus, link clock stands still
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   // Data falls while clock high, clock left low
   task automatic start();
      sda_m <= 1'b1;
      scl_m <= 1'b1;
      cyc(4);
      sda_m <= 1'b0;
      cyc(4);
      scl_m <= 1'b0;
   endtask : start
   // Data rises while clock high
   task automatic stop();
      cyc(2);
      sda_m <= 1'b0;
      cyc(3);
      scl_m <= 1'b1;
      cyc(4);
      sda_m <= 1'b1;
      cyc(4);
   endtask : stop
   // One pulse of 400 ns, honours stretching, samples while high
   task automatic bitx(input logic b, output logic r);
      cyc(2);
      sda_m <= b;
      cyc(3);
      scl_m <= 1'b1;
      cyc(1);
      for (int i = 0; i < 50 && !scl_w; i++)
         cyc(1);
      r = sda_w;
      cyc(2);
      scl_m <= 1'b0;
   endtask : bitx
   // Byte MSB first, then the acknowledge pulse
   task automatic xbyte(input logic [7:0] d, input logic a,
                        output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], q[i]);
      bitx(a, k);
   endtask : xbyte
endmodule : isd_master

//--- test/isd_slave_timeout_tb.sv
// Testbench of the slave data and time-out block
`timescale 1ns/100ps
module isd_slave_timeout_tb;
   logic clock;
   logic reset_n;
   isd_pkg::isd_reg_req_t req;
   logic [7:0] rdata;
   wire isd_pkg::isd_pin_in_t pin_in;
   isd_pkg::isd_pin_out_t pin_out;
   logic irq;
   logic scl_m;
   logic sda_m;
   int errors;
   int checks;
   logic [7:0] q;
   logic [7:0] v;
   logic k;
   // Wire levels, pull-ups on both lines
   assign pin_in = {scl_m & (pin_out.scl_oe_n | pin_out.scl_o),
                    sda_m & (pin_out.sda_oe_n | pin_out.sda_o)};
   isd_slave_timeout dut (.clock(clock), .reset_n(reset_n), .reg_req(req),
      .reg_rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
   isd_master m (.clock(clock), .scl_w(pin_in.scl_i),
      .sda_w(pin_in.sda_i), .scl_m(scl_m), .sda_m(sda_m));
   // 20 MHz clock
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   // Wait n edges, then step past the output update
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wt
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clock);
      req.wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clock);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic chkb(input string n, input logic e, input logic g);
      chk(n, {7'h00, e}, {7'h00, g});
   endtask : chkb
   task automatic final_report();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(isd_pkg::ADDR_TIMEOUT_CTRL, v);
      chk("timeout_ctrl", 8'h00, v);
      wr(isd_pkg::ADDR_TIMEOUT_CTRL, 8'h3F);
      rd(isd_pkg::ADDR_TIMEOUT_CTRL, v);
      chk("period_rw", 8'h3F, v);
      wr(isd_pkg::ADDR_TIMEOUT_CTRL, 8'h00);
      rd(3'h7, v);
      chk("unmapped", 8'h00, v);
      chkb("scl_oe_n", 1'b1, pin_out.scl_oe_n);
      chkb("irq", 1'b0, irq);
   endtask : t_reset
   task automatic t_rx();
      m.start();
      m.xbyte(8'hB0, 1'b1, q, k);
      chkb("addr_nack", 1'b1, k);
      m.start();
      m.xbyte(8'hA0, 1'b1, q, k);
      chkb("addr_ack", 1'b0, k);
      rd(isd_pkg::ADDR_SLAVE_CTRL, v);
      chk("match", 8'h40, v & 8'h44);
      rd(isd_pkg::ADDR_IRQ_STATUS, v);
      chk("irq_match", 8'h01, v);
      wt(20000);
      chkb("stretch", 1'b0, pin_out.scl_oe_n);
      rd(isd_pkg::ADDR_TIMEOUT_CTRL, v);
      chk("no_timeout", 8'h00, v);
      rd(isd_pkg::ADDR_BYTE_BUFFER, v);
      wt(2);
      chkb("released", 1'b1, pin_out.scl_oe_n);
      m.xbyte(8'hC3, 1'b1, q, k);
      chkb("data_ack", 1'b0, k);
      rd(isd_pkg::ADDR_BYTE_BUFFER, v);
      chk("rx_byte", 8'hC3, v);
      rd(isd_pkg::ADDR_IRQ_STATUS, v);
      chk("irq_byte", 8'h02, v);
      wr(isd_pkg::ADDR_SLAVE_CTRL, 8'h08);
      m.xbyte(8'h5A, 1'b1, q, k);
      chkb("ack_value", 1'b1, k);
      rd(isd_pkg::ADDR_BYTE_BUFFER, v);
      chk("rx_byte2", 8'h5A, v);
      m.stop();
      rd(isd_pkg::ADDR_IRQ_STATUS, v);
   endtask : t_rx
   task automatic t_tx();
      wr(isd_pkg::ADDR_TIMEOUT_CTRL, 8'h80);
      m.start();
      m.xbyte(8'hA1, 1'b1, q, k);
      rd(isd_pkg::ADDR_SLAVE_CTRL, v);
      chk("read_req", 8'h44, v & 8'h44);
      rd(isd_pkg::ADDR_IRQ_STATUS, v);
      wr(isd_pkg::ADDR_SLAVE_CTRL, 8'h10);
      wr(isd_pkg::ADDR_BYTE_BUFFER, 8'h96);
      wt(2);
      chkb("tx_release", 1'b1, pin_out.scl_oe_n);
      for (int i = 7; i >= 0; i--)
         m.bitx(1'b1, q[i]);
      chk("tx_byte", 8'h96, q);
      // Next byte loaded while the acknowledge pulse is high
      fork
         m.bitx(1'b0, k);
         begin
            @(posedge pin_in.scl_i);
            wt(1);
            wr(isd_pkg::ADDR_BYTE_BUFFER, 8'h3C);
         end
      join
      m.xbyte(8'hFF, 1'b1, q, k);
      chk("tx_byte2", 8'h3C, q);
      wt(8);
      chkb("nack_release", 1'b1, pin_out.sda_oe_n);
      rd(isd_pkg::ADDR_SLAVE_CTRL, v);
      chk("ack_flag", 8'h01, v & 8'h01);
      m.stop();
      rd(isd_pkg::ADDR_IRQ_STATUS, v);
      wt(20500);
      rd(isd_pkg::ADDR_TIMEOUT_CTRL, v);
      chk("stop_halts", 8'h80, v);
   endtask : t_tx
   task automatic t_tout();
      int n;
      wr(isd_pkg::ADDR_TIMEOUT_CTRL, 8'h80);
      m.start();
      m.xbyte(8'hA0, 1'b1, q, k);
      rd(isd_pkg::ADDR_IRQ_STATUS, v);
      wt(31 * isd_pkg::SUB_DIV_CYCLES - 40);
      chkb("early", 1'b0, pin_out.scl_oe_n);
      n = 0;
      while (!pin_out.scl_oe_n && n < 2 * isd_pkg::SUB_DIV_CYCLES + 80) begin
         wt(1);
         n++;
      end
      chkb("timeout", 1'b1, pin_out.scl_oe_n);
      wt(2);
      chkb("irq_tout", 1'b1, irq);
      rd(isd_pkg::ADDR_TIMEOUT_CTRL, v);
      chk("tout_ctrl", 8'h40, v);
      rd(isd_pkg::ADDR_IRQ_STATUS, v);
      chk("tout_status", 8'h04, v);
      rd(isd_pkg::ADDR_SLAVE_CTRL, v);
      chk("slave_ctrl", 8'h00, v);
      rd(isd_pkg::ADDR_OWN_ADDRESS, v);
      chk("own_addr", 8'hA0, v);
      rd(isd_pkg::ADDR_PRIMARY_CTRL, v);
      chk("primary", 8'h01, v);
      wr(isd_pkg::ADDR_TIMEOUT_CTRL, 8'h40);
      rd(isd_pkg::ADDR_TIMEOUT_CTRL, v);
      chk("flag_keep", 8'h40, v);
      wr(isd_pkg::ADDR_TIMEOUT_CTRL, 8'h00);
      rd(isd_pkg::ADDR_TIMEOUT_CTRL, v);
      chk("flag_clear", 8'h00, v);
      m.stop();
   endtask : t_tout
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      errors = 0;
      checks = 0;
      reset_n = 1'b0;
      req = '0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      t_reset();
      wr(isd_pkg::ADDR_OWN_ADDRESS, 8'hA0);
      wr(isd_pkg::ADDR_PRIMARY_CTRL, 8'h01);
      wr(isd_pkg::ADDR_IRQ_MASK, 8'h07);
      t_rx();
      t_tx();
      t_tout();
      final_report();
   end
   // Watchdog
   initial begin
      wt(90000);
      errors++;
      final_report();
   end
endmodule : isd_slave_timeout_tb

//--- test/isd_sva.sv
// Port checker of the slave data and time-out block
`timescale 1ns/100ps
module isd_sva (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Watched ports
   input wire isd_pkg::isd_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire isd_pkg::isd_pin_in_t pin_in,
   input wire isd_pkg::isd_pin_out_t pin_out,
   input wire logic irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic acc_q;
   logic txm_q;
   // Transmit mode as last written by software
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         txm_q <= 1'b0;
      else if (reg_req.wr && reg_req.addr == isd_pkg::ADDR_SLAVE_CTRL)
         txm_q <= reg_req.wdata[isd_pkg::SCS_TXMODE_BIT];
   end
   wire acc = (reg_req.rd | reg_req.wr) &&
      reg_req.addr == isd_pkg::ADDR_BYTE_BUFFER;
   // Buffer access seen one cycle ago
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         acc_q <= 1'b0;
      else
         acc_q <= acc;
   end
   sequence s_buf_rd;
      reg_req.rd && reg_req.addr == isd_pkg::ADDR_BYTE_BUFFER && !txm_q;
   endsequence
   sequence s_stretched;
      !pin_out.scl_oe_n;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_rdata_idle: assert property (!$past(reg_req.rd) |->
      reg_rdata == 8'h00) else $error("read data outside read cycle");
   a_unmapped_rd: assert property ($past(reg_req.rd) &&
      $past(reg_req.addr) == 3'h7 |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_scl_low_only: assert property (pin_out.scl_o == 1'b0)
      else $error("clock line driven high");
   a_sda_low_only: assert property (pin_out.sda_o == 1'b0)
      else $error("data line driven high");
   a_stretch_rel: assert property (s_stretched ##0 s_buf_rd |->
      ##[1:2] pin_out.scl_oe_n) else $error("stretch kept after read");
   a_rel_cause: assert property ($rose(pin_out.scl_oe_n) &&
      !acc_q && !$past(acc_q) |-> ##[0:2] irq)
      else $error("clock released without cause");
   a_irq_rd_clr: assert property (reg_req.rd &&
      reg_req.addr == isd_pkg::ADDR_IRQ_STATUS |-> ##1 !irq)
      else $error("interrupt kept after status read");
   a_sda_low_phase: assert property ($fell(pin_out.sda_oe_n) |->
      !pin_in.scl_i) else $error("data driven while clock high");
endmodule : isd_sva
bind isd_slave_timeout isd_sva u_sva (.clock(clock), .reset_n(reset_n),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .pin_in(pin_in),
   .pin_out(pin_out), .irq(irq));
